//--- rtl/osu_consts.vh
// Purpose: Constants for the oscillator select and start-up block.
// Assumes: Included by every design file of the block.
// Notes:   Codes are the configuration field encodings.
`ifndef OSU_CONSTS_VH
`define OSU_CONSTS_VH
// ======================================================
// Group selector codes
`define OSU_GRP_SECONDARY 2'h0
`define OSU_GRP_FAST_RC   2'h1
`define OSU_GRP_LP_RC     2'h2
`define OSU_GRP_PRIMARY   2'h3
// ======================================================
// Primary mode selector codes
`define OSU_PM_LOW_XTAL   4'h0
`define OSU_PM_FRC_X4     4'h1
`define OSU_PM_HS_XTAL    4'h2
`define OSU_PM_FRC_X16    4'h3
`define OSU_PM_MID_XTAL   4'h4
`define OSU_PM_MID_X4     4'h5
`define OSU_PM_MID_X8     4'h6
`define OSU_PM_MID_X16    4'h7
`define OSU_PM_ERC_IO     4'h8
`define OSU_PM_ERC        4'h9
`define OSU_PM_FRC_X8     4'ha
`define OSU_PM_EXT        4'hb
`define OSU_PM_EXT_IO     4'hc
`define OSU_PM_EXT_X4     4'hd
`define OSU_PM_EXT_X8     4'he
`define OSU_PM_EXT_X16    4'hf
// ======================================================
// Multiplier gain codes
`define OSU_MUL_OFF       2'h0
`define OSU_MUL_X4        2'h1
`define OSU_MUL_X8        2'h2
`define OSU_MUL_X16       2'h3
// ======================================================
// Multiplier source codes
`define OSU_MSRC_PRIMARY  1'b0
`define OSU_MSRC_FAST_RC  1'b1
// ======================================================
// Second pin function codes
`define OSU_PIN2_CLKOUT   2'h0
`define OSU_PIN2_GPIO     2'h1
`define OSU_PIN2_CRYSTAL  2'h2
// ======================================================
// Start-up counter
`define OSU_STARTUP_WIDTH 10
`define OSU_STARTUP_MAX   10'h3ff
// ======================================================
// Clock control register field positions
`define OSU_CCR_TRIM_HI_MSB 15
`define OSU_CCR_TRIM_HI_LSB 14
`define OSU_CCR_COSC_MSB    13
`define OSU_CCR_COSC_LSB    12
`define OSU_CCR_TRIM_LO_MSB 11
`define OSU_CCR_TRIM_LO_LSB 10
`define OSU_CCR_NOSC_MSB    9
`define OSU_CCR_NOSC_LSB    8
`define OSU_CCR_LOCK_BIT    5
`define OSU_CCR_SEC_EN_BIT  1
`define OSU_CCR_RESET       16'h0000
// ======================================================
// Trim
`define OSU_TRIM_CENTER   4'h0
`define OSU_TRIM_STEP_BP  8'h96
`endif

//--- rtl/osu_startup_counter.v
// Purpose: Start-up delay counter running on the oscillator being started.
// Assumes: osc_clk is the restarting oscillator; restart and apply are slow system levels.
// Notes:   Release holds until the next restart.
`timescale 1ns/1ps
`include "osu_consts.vh"
module osu_startup_counter
#(
  parameter WIDTH = `OSU_STARTUP_WIDTH
)
(
  input  wire             osc_clk,
  input  wire             rstn,
  input  wire             restart,
  input  wire             apply,
  output reg              released_reg
);
  // ======================================================
  // Counter
  reg  [WIDTH-1:0] count_reg;
  reg              restart_meta_reg;
  reg              restart_sync_reg;
  reg              apply_meta_reg;
  reg              apply_sync_reg;
  wire             terminal;
  assign terminal = (count_reg == {WIDTH{1'b1}});
  always @(posedge osc_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      restart_meta_reg <= 1'b1;
      restart_sync_reg <= 1'b1;
    end
    else
    begin
      restart_meta_reg <= restart;
      restart_sync_reg <= restart_meta_reg;
    end
  end
  // Apply comes from the system clock, so it is resynchronised like restart.
  // It resets high, which errs towards a full delay rather than an early release.
  always @(posedge osc_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      apply_meta_reg <= 1'b1;
      apply_sync_reg <= 1'b1;
    end
    else
    begin
      apply_meta_reg <= apply;
      apply_sync_reg <= apply_meta_reg;
    end
  end
  // Clearing on every restart means a stale count never shortens the delay.
  always @(posedge osc_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count_reg    <= {WIDTH{1'b0}};
      released_reg <= 1'b0;
    end
    else if (restart_sync_reg)
    begin
      count_reg    <= {WIDTH{1'b0}};
      released_reg <= 1'b0;
    end
    else if (!apply_sync_reg)
    begin
      released_reg <= 1'b1;
    end
    else if (!released_reg)
    begin
      count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      if (terminal)
      begin
        released_reg <= 1'b1;
      end
    end
  end
endmodule

//--- rtl/osu_oscillator_select.v
// Purpose: Clock source choice, pin functions, start-up gating and trim.
// Assumes: Configuration fields are stable while reset is applied.
// Notes:   Clock switching, fail-safe monitor and postscaler live elsewhere.
//
// Contract
// - Pick clock from two fields after reset.
// - Decode group selector into four groups.
// - Decode primary mode selector into primary modes.
// - Primary codes 1/a/3 run fast RC multiplied.
// - Second pin follows mode: clock-out, I/O, crystal.
// - First pin never released to general I/O.
// - Ten-bit counter counts 1024 oscillator periods.
// - Delay on reset/wake, crystal modes only.
// - Secondary oscillator runs whenever enabled, even sleep.
// - Secondary is clock only for group 00 enabled.
// - Multiplier from primary or fast RC, x4/x8/x16.
// - Lock bit follows multiplier lock, clears on loss.
// - Fast RC runs when current group is 01 and not sleeping.
// - Trim field split at bits 15:14, 11:10.
// - Trim is signed code, 1.5 percent steps.
// - Return from secondary to a crystal mode incurs main start-up delay.
// - Reset loads current and new group from config.
`timescale 1ns/1ps
`include "osu_consts.vh"
module osu_oscillator_select
#(
  parameter STARTUP_WIDTH = `OSU_STARTUP_WIDTH
)
(
  input  wire        clk,
  input  wire        rstn,
  input  wire        main_osc_clk,
  input  wire        secondary_osc_clk,
  input  wire [1:0]  cfg_group_select,
  input  wire [3:0]  cfg_primary_mode_select,
  input  wire        reset_load,
  input  wire        sleep_req,
  input  wire        wake_evt,
  input  wire        new_group_wr,
  input  wire [1:0]  new_group_wdata,
  input  wire        secondary_osc_enable_wr,
  input  wire        secondary_osc_enable_wdata,
  input  wire        trim_wr,
  input  wire [3:0]  trim_wdata,
  input  wire        pll_lock_raw,
  output reg  [1:0]  current_group_status,
  output reg  [1:0]  new_group_request,
  output reg         secondary_osc_enable,
  output reg  [3:0]  fast_rc_trim,
  output reg  [15:0] clock_control_register,
  output reg         sleeping,
  output reg         primary_osc_run,
  output reg         secondary_osc_run,
  output reg         fast_rc_run,
  output reg         low_power_rc_run,
  output reg         pll_enable,
  output reg  [1:0]  pll_gain,
  output reg         pll_source,
  output reg  [1:0]  oscillator_second_pin_function,
  output reg         oscillator_input_pin_gpio,
  output reg         secondary_is_device_clock,
  output reg         startup_applies,
  output wire        main_clock_released,
  output wire        secondary_clock_released,
  output reg         pll_lock
);
  // ======================================================
  // Decode of the primary mode selector
  reg  [1:0] pm_gain;
  reg        pm_src;
  reg  [1:0] pm_pin2;
  reg        pm_crystal;
  reg        pm_is_frc;
  always @*
  begin
    pm_gain    = `OSU_MUL_OFF;
    pm_src     = `OSU_MSRC_PRIMARY;
    pm_pin2    = `OSU_PIN2_GPIO;
    pm_crystal = 1'b0;
    pm_is_frc  = 1'b0;
    case (cfg_primary_mode_select)
      `OSU_PM_EXT:      pm_pin2 = `OSU_PIN2_CLKOUT;
      `OSU_PM_EXT_IO:   pm_pin2 = `OSU_PIN2_GPIO;
      `OSU_PM_EXT_X4:   pm_gain = `OSU_MUL_X4;
      `OSU_PM_EXT_X8:   pm_gain = `OSU_MUL_X8;
      `OSU_PM_EXT_X16:  pm_gain = `OSU_MUL_X16;
      `OSU_PM_ERC:      pm_pin2 = `OSU_PIN2_CLKOUT;
      `OSU_PM_ERC_IO:   pm_pin2 = `OSU_PIN2_GPIO;
      `OSU_PM_MID_XTAL, `OSU_PM_LOW_XTAL, `OSU_PM_HS_XTAL:
      begin
        pm_pin2    = `OSU_PIN2_CRYSTAL;
        pm_crystal = 1'b1;
      end
      `OSU_PM_MID_X4, `OSU_PM_MID_X8, `OSU_PM_MID_X16:
      begin
        pm_pin2    = `OSU_PIN2_CRYSTAL;
        pm_crystal = 1'b1;
        pm_gain    = cfg_primary_mode_select[1:0];
      end
      `OSU_PM_FRC_X4:
      begin
        pm_gain   = `OSU_MUL_X4;
        pm_src    = `OSU_MSRC_FAST_RC;
        pm_is_frc = 1'b1;
      end
      `OSU_PM_FRC_X8:
      begin
        pm_gain   = `OSU_MUL_X8;
        pm_src    = `OSU_MSRC_FAST_RC;
        pm_is_frc = 1'b1;
      end
      `OSU_PM_FRC_X16:
      begin
        pm_gain   = `OSU_MUL_X16;
        pm_src    = `OSU_MSRC_FAST_RC;
        pm_is_frc = 1'b1;
      end
      default:
      begin
        pm_gain = `OSU_MUL_OFF;
      end
    endcase
  end
  // ======================================================
  // Group and control state
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      current_group_status <= `OSU_GRP_PRIMARY;
      new_group_request    <= `OSU_GRP_PRIMARY;
      secondary_osc_enable <= 1'b0;
      fast_rc_trim         <= `OSU_TRIM_CENTER;
      sleeping             <= 1'b0;
    end
    else
    begin
      if (reset_load)
      begin
        current_group_status <= cfg_group_select;
        new_group_request    <= cfg_group_select;
      end
      else if (new_group_wr)
      begin
        new_group_request <= new_group_wdata;
      end
      if (secondary_osc_enable_wr)
      begin
        secondary_osc_enable <= secondary_osc_enable_wdata;
      end
      if (trim_wr)
      begin
        fast_rc_trim <= trim_wdata;
      end
      if (reset_load || wake_evt)
      begin
        sleeping <= 1'b0;
      end
      else if (sleep_req)
      begin
        sleeping <= 1'b1;
      end
    end
  end
  // ======================================================
  // Lock status through a two-stage synchroniser
  reg lock_meta_reg;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lock_meta_reg <= 1'b0;
      pll_lock      <= 1'b0;
    end
    else
    begin
      lock_meta_reg <= pll_lock_raw;
      pll_lock      <= lock_meta_reg & pll_enable;
    end
  end
  // ======================================================
  // Source enables, multiplier and pins
  wire [1:0] grp;
  assign grp = current_group_status;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      primary_osc_run                <= 1'b0;
      secondary_osc_run              <= 1'b0;
      fast_rc_run                    <= 1'b0;
      low_power_rc_run               <= 1'b1;
      pll_enable                     <= 1'b0;
      pll_gain                       <= `OSU_MUL_OFF;
      pll_source                     <= `OSU_MSRC_PRIMARY;
      oscillator_second_pin_function <= `OSU_PIN2_CRYSTAL;
      oscillator_input_pin_gpio      <= 1'b0;
      secondary_is_device_clock      <= 1'b0;
      startup_applies                <= 1'b0;
    end
    else
    begin
      primary_osc_run   <= (grp == `OSU_GRP_PRIMARY) && !pm_is_frc && !sleeping;
      secondary_osc_run <= secondary_osc_enable;
      fast_rc_run       <= ((grp == `OSU_GRP_FAST_RC) ||
                            ((grp == `OSU_GRP_PRIMARY) && pm_is_frc)) && !sleeping;
      low_power_rc_run  <= (grp == `OSU_GRP_LP_RC) || reset_load;
      pll_enable        <= (grp == `OSU_GRP_PRIMARY) && (pm_gain != `OSU_MUL_OFF)
                           && !sleeping;
      pll_gain          <= (grp == `OSU_GRP_PRIMARY) ? pm_gain : `OSU_MUL_OFF;
      pll_source        <= pm_src;
      oscillator_second_pin_function <= pm_pin2;
      oscillator_input_pin_gpio      <= 1'b0;
      secondary_is_device_clock <= (grp == `OSU_GRP_SECONDARY) && secondary_osc_enable;
      startup_applies   <= (grp == `OSU_GRP_PRIMARY) && pm_crystal;
    end
  end
  // ======================================================
  // Clock control register image
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clock_control_register <= `OSU_CCR_RESET;
    end
    else
    begin
      clock_control_register <= `OSU_CCR_RESET;
      clock_control_register[`OSU_CCR_TRIM_HI_MSB:`OSU_CCR_TRIM_HI_LSB] <= fast_rc_trim[3:2];
      clock_control_register[`OSU_CCR_TRIM_LO_MSB:`OSU_CCR_TRIM_LO_LSB] <= fast_rc_trim[1:0];
      clock_control_register[`OSU_CCR_COSC_MSB:`OSU_CCR_COSC_LSB] <= current_group_status;
      clock_control_register[`OSU_CCR_NOSC_MSB:`OSU_CCR_NOSC_LSB] <= new_group_request;
      clock_control_register[`OSU_CCR_LOCK_BIT]   <= pll_lock;
      clock_control_register[`OSU_CCR_SEC_EN_BIT] <= secondary_osc_enable;
    end
  end
  // ======================================================
  // Start-up delays
  // Restart is raised at reset load, in sleep and on wake, so each return to a crystal,
  // including the return from the secondary oscillator, waits a full count.
  reg  restart_main_reg;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      restart_main_reg <= 1'b1;
    end
    else
    begin
      restart_main_reg <= reset_load || sleeping || wake_evt || !primary_osc_run;
    end
  end
  osu_startup_counter
  #(
    .WIDTH (STARTUP_WIDTH)
  )
  u_main_startup
  (
    .osc_clk      (main_osc_clk),
    .rstn         (rstn),
    .restart      (restart_main_reg),
    .apply        (startup_applies),
    .released_reg (main_clock_released)
  );
  // The secondary crystal keeps running through sleep, so only reset load or clearing its enable restarts it.
  reg  restart_sec_reg;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      restart_sec_reg <= 1'b1;
    end
    else
    begin
      restart_sec_reg <= reset_load || !secondary_osc_enable;
    end
  end
  osu_startup_counter
  #(
    .WIDTH (STARTUP_WIDTH)
  )
  u_sec_startup
  (
    .osc_clk      (secondary_osc_clk),
    .rstn         (rstn),
    .restart      (restart_sec_reg),
    .apply        (1'b1),
    .released_reg (secondary_clock_released)
  );
endmodule

//--- dv/osu_dec.svh
// Purpose: Expected primary mode decode for the bench side.
// Assumes: Included inside a module body.
// Notes:   Result is {second pin function, multiplier gain, multiplier source}.
function automatic logic [4:0] osu_dec(input logic [3:0] m);
  case (m)
    4'h0, 4'h2, 4'h4: osu_dec = 5'h10;
    4'h5: osu_dec = 5'h12;
    4'h6: osu_dec = 5'h14;
    4'h7: osu_dec = 5'h16;
    4'h1: osu_dec = 5'h0b;
    4'ha: osu_dec = 5'h0d;
    4'h3: osu_dec = 5'h0f;
    4'h9, 4'hb: osu_dec = 5'h00;
    4'hd: osu_dec = 5'h0a;
    4'he: osu_dec = 5'h0c;
    4'hf: osu_dec = 5'h0e;
    default: osu_dec = 5'h08;
  endcase
endfunction

//--- dv/osu_checker.sv
// Purpose: Port assertions for the oscillator select block.
// Assumes: Derived outputs follow their state one clock later.
// Notes:   Decode checks wait until mode and group have been held, so
//          the two-edge group latency never raises a false alarm.
`timescale 1ns/1ps
module osu_checker
(
  input logic        clk,
  input logic        rstn,
  input logic [1:0]  cfg_group_select,
  input logic [3:0]  cfg_primary_mode_select,
  input logic        reset_load,
  input logic        pll_lock_raw,
  input logic [1:0]  current_group_status,
  input logic [1:0]  new_group_request,
  input logic        secondary_osc_enable,
  input logic [3:0]  fast_rc_trim,
  input logic [15:0] clock_control_register,
  input logic        fast_rc_run,
  input logic        pll_enable,
  input logic [1:0]  pll_gain,
  input logic        pll_source,
  input logic [1:0]  oscillator_second_pin_function,
  input logic        oscillator_input_pin_gpio,
  input logic        secondary_is_device_clock,
  input logic        startup_applies,
  input logic        pll_lock
);
  `include "osu_dec.svh"
  // ======================================================
  // Hold tracking
  logic [5:0] prev_reg;
  logic [1:0] hold_reg;
  logic       held;
  logic [4:0] want;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      prev_reg <= 6'h00;
      hold_reg <= 2'h0;
    end
    else
    begin
      prev_reg <= {cfg_primary_mode_select, current_group_status};
      if (prev_reg != {cfg_primary_mode_select, current_group_status})
        hold_reg <= 2'h0;
      else if (hold_reg != 2'h3)
        hold_reg <= hold_reg + 2'h1;
    end
  assign held = hold_reg[1];
  assign want = osu_dec(prev_reg[5:2]);
  // ======================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence grp_loaded;
    current_group_status == $past(cfg_group_select) ##0
      new_group_request == $past(cfg_group_select);
  endsequence
  group_load_a: assert property (reset_load |=> grp_loaded)
    else $error("groups not loaded from configuration");
  pin2_mode_a: assert property (held |-> oscillator_second_pin_function == want[4:3])
    else $error("second pin function wrong");
  pll_decode_a: assert property (held && prev_reg[1:0] == 2'h3 |->
    {pll_gain, pll_source} == want[2:0] && pll_enable == (want[2:1] != 2'h0))
    else $error("multiplier setting wrong");
  startup_sel_a: assert property (held |->
    startup_applies == (want[4:3] == 2'h2 && prev_reg[1:0] == 2'h3))
    else $error("start-up selection wrong");
  fast_rc_a: assert property (held && prev_reg[1:0] == 2'h1 |-> fast_rc_run)
    else $error("fast RC not running");
  sec_clock_a: assert property ($past(rstn) |-> secondary_is_device_clock ==
    ($past(current_group_status) == 2'h0 && $past(secondary_osc_enable)))
    else $error("secondary clock choice wrong");
  trim_image_a: assert property ($past(rstn) |->
    {clock_control_register[15:14], clock_control_register[11:10]} == $past(fast_rc_trim)
    && clock_control_register[13:12] == $past(current_group_status))
    else $error("register image wrong");
  lock_set_a: assert property ((pll_lock_raw && pll_enable)[*4] |-> pll_lock)
    else $error("lock not shown");
  lock_clear_a: assert property ((!pll_lock_raw)[*4] |-> !pll_lock)
    else $error("lock not cleared");
  input_pin_a: assert property (!oscillator_input_pin_gpio)
    else $error("first pin released");
endmodule

bind osu_oscillator_select osu_checker chk (.clk, .rstn, .cfg_group_select,
  .cfg_primary_mode_select, .reset_load, .pll_lock_raw, .current_group_status,
  .new_group_request, .secondary_osc_enable, .fast_rc_trim, .clock_control_register,
  .fast_rc_run, .pll_enable, .pll_gain, .pll_source, .oscillator_second_pin_function,
  .oscillator_input_pin_gpio, .secondary_is_device_clock, .startup_applies, .pll_lock);

//--- dv/tb_top.sv
// Purpose: Self-checking bench for the oscillator select block.
// Assumes: Start-up counter shortened to 16 periods.
// Notes:   Restarts are timed from a stopped primary so a stale release
//          from the previous run cannot end the count early.
`timescale 1ns/1ps
module tb_top;
  `include "osu_dec.svh"
  // ======================================================
  // Signals
  logic        clk = 1'b0, rstn = 1'b0, main_osc_clk = 1'b0, secondary_osc_clk = 1'b0;
  logic [1:0]  cfg_group_select = 2'h3, new_group_wdata = 2'h0;
  logic [3:0]  cfg_primary_mode_select = 4'h4, trim_wdata = 4'h0;
  logic        reset_load = 1'b0, sleep_req = 1'b0, wake_evt = 1'b0, pll_lock_raw = 1'b0;
  logic        new_group_wr = 1'b0, trim_wr = 1'b0;
  logic        secondary_osc_enable_wr = 1'b0, secondary_osc_enable_wdata = 1'b0;
  logic [1:0]  current_group_status, new_group_request, pll_gain;
  logic [1:0]  oscillator_second_pin_function;
  logic [3:0]  fast_rc_trim;
  logic [15:0] clock_control_register;
  logic        primary_osc_run, secondary_osc_run, fast_rc_run, pll_source, pll_lock;
  logic        oscillator_input_pin_gpio, secondary_is_device_clock, startup_applies;
  logic        main_clock_released, secondary_clock_released, low_power_rc_run, sleeping;
  logic [3:0]  osu_trims [4] = '{4'h7, 4'h8, 4'hf, 4'h1};
  int          error_cnt = 0, n_compared = 0, n;
  always #12.5 clk = ~clk;
  always #5 main_osc_clk = ~main_osc_clk;
  always #41 secondary_osc_clk = ~secondary_osc_clk;
  osu_oscillator_select #(.STARTUP_WIDTH(4)) dut
  (
    .clk, .rstn, .main_osc_clk, .secondary_osc_clk, .cfg_group_select,
    .cfg_primary_mode_select, .reset_load, .sleep_req, .wake_evt, .new_group_wr,
    .new_group_wdata, .secondary_osc_enable_wr, .secondary_osc_enable_wdata, .trim_wr,
    .trim_wdata, .pll_lock_raw, .current_group_status, .new_group_request,
    .secondary_osc_enable(), .fast_rc_trim, .clock_control_register, .sleeping,
    .primary_osc_run, .secondary_osc_run, .fast_rc_run, .low_power_rc_run,
    .pll_enable(), .pll_gain, .pll_source, .oscillator_second_pin_function,
    .oscillator_input_pin_gpio, .secondary_is_device_clock, .startup_applies,
    .main_clock_released, .secondary_clock_released, .pll_lock
  );
  // ======================================================
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic load(input logic [1:0] g, input logic [3:0] m);
    @(posedge clk);
    cfg_group_select <= g;
    cfg_primary_mode_select <= m;
    reset_load <= 1'b1;
    @(posedge clk);
    reset_load <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] t, input logic s);
    @(posedge clk);
    trim_wdata <= t;
    secondary_osc_enable_wdata <= s;
    trim_wr <= 1'b1;
    secondary_osc_enable_wr <= 1'b1;
    @(posedge clk);
    trim_wr <= 1'b0;
    secondary_osc_enable_wr <= 1'b0;
    cyc(4);
  endtask
  task automatic pulse(input logic w);
    @(posedge clk);
    if (w)
      wake_evt <= 1'b1;
    else
      sleep_req <= 1'b1;
    @(posedge clk);
    wake_evt <= 1'b0;
    sleep_req <= 1'b0;
  endtask
  // Counts main oscillator periods until the clock is let through.
  task automatic rel;
    n = 0;
    while (main_clock_released !== 1'b1 && n < 200)
    begin
      @(posedge main_osc_clk);
      n++;
    end
  endtask
  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ======================================================
  // Tests
  initial
  begin
    #500000;
    error_cnt++;
    finish_test;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    for (int m = 0; m < 16; m++)
    begin
      load(2'h3, m[3:0]);
      cyc(4);
      chk({oscillator_second_pin_function, pll_gain, pll_source}, osu_dec(m[3:0]));
      chk(startup_applies, osu_dec(m[3:0]) >= 5'h10);
      chk({primary_osc_run, fast_rc_run}, osu_dec(m[3:0]) & 5'h01 ? 2'h1 : 2'h2);
      chk(oscillator_input_pin_gpio, 1'b0);
    end
    $display("test mode table done");
    for (int g = 0; g < 4; g++)
    begin
      load(g[1:0], 4'h0);
      cyc(4);
      chk({current_group_status, new_group_request}, {g[1:0], g[1:0]});
      chk(clock_control_register[13:8], {g[1:0], 2'h0, g[1:0]});
      chk({fast_rc_run, primary_osc_run}, {g == 1, g == 3});
      chk(low_power_rc_run, g == 2);
      chk(oscillator_second_pin_function, 2'h2);
    end
    $display("test groups done");
    wr(4'h0, 1'b1);
    chk({secondary_is_device_clock, secondary_osc_run}, 2'h1);
    cyc(60);
    chk(secondary_clock_released, 1'b1);
    load(2'h0, 4'h0);
    cyc(4);
    chk({secondary_is_device_clock, clock_control_register[1]}, 2'h3);
    pulse(1'b0);
    cyc(3);
    chk({secondary_osc_run, sleeping}, 2'h3);
    pulse(1'b1);
    wr(4'h0, 1'b0);
    chk(secondary_is_device_clock, 1'b0);
    $display("test secondary done");
    foreach (osu_trims[i])
    begin
      wr(osu_trims[i], 1'b0);
      chk(fast_rc_trim, osu_trims[i]);
      chk({clock_control_register[15:14], clock_control_register[11:10]}, osu_trims[i]);
    end
    $display("test trim done");
    chk(main_clock_released, 1'b0);
    load(2'h3, 4'h4);
    rel;
    chk(n >= 16 && n <= 32, 1'b1);
    pulse(1'b0);
    cyc(4);
    chk(main_clock_released, 1'b0);
    pulse(1'b1);
    rel;
    chk(n >= 16 && n <= 32, 1'b1);
    load(2'h0, 4'hb);
    cyc(4);
    load(2'h3, 4'hb);
    rel;
    chk(n < 16, 1'b1);
    $display("test start-up done");
    load(2'h3, 4'h5);
    pll_lock_raw <= 1'b1;
    cyc(8);
    chk(pll_lock, 1'b1);
    @(posedge clk);
    pll_lock_raw <= 1'b0;
    cyc(6);
    chk(pll_lock, 1'b0);
    $display("test lock done");
    finish_test;
  end
endmodule
